// *** src/ppe_map.svh ***
// Operation
// R1 - offsets: data, status, control, address, four data
// R2 - enhanced ports answer only in enhanced mode
// R3 - data read returns the output latch
// R4 - status bit 7 is inverted busy pin
// R5 - status bit 6 is live acknowledge level
// R6 - status bits 5,4,3: paper, selected, fault
// R7 - status bits 2 and 1 read one
// R8 - bit 0 timeout flag, write one clears
// R9 - control bits 7 and 6 read one
// R10 - control bit 5 direction, zero in compatible mode
// R11 - bit 4 enables acknowledge rising-edge interrupt
// R12 - control bit 3 drives select-in active
// R13 - control bit 2 drives init, hold 50us
// R14 - control bit 1 drives auto line-feed
// R15 - host holds strobe and data 0.5us
// R16 - address write drives latched host data
// R17 - address read samples lines to host
// R18 - data ports run same data cycles
// R19 - direction, data and address strobes per cycle
// R20 - peripheral raises wait when transfer done
// R21 - init output returns peripheral to start
// R22 - peripheral interrupts on acknowledge input
// R23 - abort cycle after 10us without wait release
// R24 - newer variant waits for wait low first
// R25 - interrupt pends until host services it
`ifndef PPE_MAP_SVH
`define PPE_MAP_SVH
// register offsets on the three address bits
`define PPE_OFF_DATA 3'h0
`define PPE_OFF_STATUS 3'h1
`define PPE_OFF_CTRL 3'h2
`define PPE_OFF_EADDR 3'h3
`define PPE_OFF_EDATA0 3'h4
// control field positions
`define PPE_CT_STB 0
`define PPE_CT_AFD 1
`define PPE_CT_INIT 2
`define PPE_CT_SELECT_CTRL_BIT 3
`define PPE_CT_ACK_IRQ_ENABLE 4
`define PPE_CT_DIR 5
// reset values
`define PPE_CTRL_RST 8'hC4
`define PPE_DATA_RST 8'h00
`define PPE_UNMAPPED 8'hFF
// timing
`define PPE_CLK_NS 100
`define PPE_TMO_NS 10000
`define PPE_TMO_CYC ((`PPE_TMO_NS + `PPE_CLK_NS - 1) / `PPE_CLK_NS)
`endif

// *** src/ppe_pkg.sv ***
package ppe_pkg;
   // enhanced cycle engine states
   typedef enum logic [1:0] {
      PPE_IDLE = 2'b00,
      PPE_WLOW = 2'b01,
      PPE_STRB = 2'b10,
      PPE_END = 2'b11
   } ppe_state_t;
   // buffered request: {is_address, is_read, data}
   typedef logic [9:0] ppe_req_t;
endpackage : ppe_pkg

// *** src/ppe_port.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ppe_map.svh"
module ppe_port
   import ppe_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic SRST,
   // host i/o access
   input wire logic [2:0] IO_ADDR,
   input wire logic IO_RD_N,
   input wire logic IO_WR_N,
   input wire logic [7:0] HOST_DATA_BUS_IN,
   output logic [7:0] HOST_DATA_BUS_OUT,
   output logic HOST_DATA_BUS_OE,
   output logic HOST_READY,
   output logic HOST_IRQ,
   // mode straps
   input wire logic EPP_MODE,
   input wire logic EPP_V19,
   // parallel data lines
   input wire logic [7:0] PARALLEL_DATA_LINES_IN,
   output logic [7:0] PARALLEL_DATA_LINES_OUT,
   output logic PARALLEL_DATA_LINES_OE,
   // peripheral control outputs
   output logic DATA_STROBE_OUT_N,
   output logic AUTO_LINEFEED_OUT_N,
   output logic PERIPHERAL_INIT_OUT_N,
   output logic SELECT_IN_OUT_N,
   // peripheral status inputs
   input wire logic ACKNOWLEDGE_IN_N,
   input wire logic BUSY_WAIT_IN,
   input wire logic PAPER_END_IN,
   input wire logic SELECTED_IN,
   input wire logic FAULT_IN_N
);

   localparam logic [6:0] TMO_LAST = 7'(`PPE_TMO_CYC);

   // host side registers
   logic [7:0] data_q, data_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] hout_q, hout_d;
   logic tmo_q, tmo_d;
   logic irq_q, irq_d;
   logic ack_q, ack_d;
   logic rd_q, rd_d;
   logic wr_q, wr_d;
   logic pend_q, pend_d;
   ppe_req_t pend_ent_q, pend_ent_d;
   logic rwait_q, rwait_d;
   // buffer
   ppe_req_t buf_q [2];
   ppe_req_t buf_d [2];
   logic wptr_q, wptr_d, rptr_q, rptr_d;
   logic [1:0] cnt_q, cnt_d;
   logic buf_push, buf_pop, buf_in_ready, buf_out_valid;
   // engine
   ppe_state_t st_q, st_d;
   logic [6:0] tcnt_q, tcnt_d;
   logic seen_q, seen_d;
   logic cur_addr_q, cur_addr_d, cur_read_q, cur_read_d;
   logic [7:0] cur_data_q, cur_data_d;
   logic [7:0] erd_q, erd_d;
   logic done_q, done_d;
   logic tmo_set;
   logic rd_lead, wr_lead, is_enh, stat_rd, stat_clr, ack_rise;
   logic [7:0] status_val, ctrl_rb;

   // offset classes shared by read and write decode
   function automatic logic enh_port(input logic [2:0] a);
      enh_port = (a >= `PPE_OFF_EADDR);
   endfunction : enh_port

   // strobe edges and status views
   assign rd_lead = rd_q && !IO_RD_N && HOST_READY;
   assign wr_lead = wr_q && !IO_WR_N && HOST_READY;
   assign is_enh = enh_port(IO_ADDR) && EPP_MODE; // see R2
   assign status_val = {!BUSY_WAIT_IN, ACKNOWLEDGE_IN_N, PAPER_END_IN, SELECTED_IN,
                        FAULT_IN_N, 2'b11, tmo_q && EPP_MODE}; // see R4 see R5 see R6 see R7
   assign ctrl_rb = {2'b11, ctrl_q[5:0]}; // see R9
   assign stat_rd = rd_lead && (IO_ADDR == `PPE_OFF_STATUS);
   assign stat_clr = wr_lead && (IO_ADDR == `PPE_OFF_STATUS) && HOST_DATA_BUS_IN[0];
   assign ack_rise = ACKNOWLEDGE_IN_N && !ack_q;

   // host register decode and access tracking
   always_comb begin
      data_d = data_q;
      ctrl_d = ctrl_q;
      hout_d = hout_q;
      pend_d = pend_q && !buf_push;
      pend_ent_d = pend_ent_q;
      rwait_d = rwait_q;
      rd_d = IO_RD_N;
      wr_d = IO_WR_N;
      ack_d = ACKNOWLEDGE_IN_N;
      tmo_d = tmo_set || (tmo_q && !stat_clr); // see R8
      irq_d = (ack_rise && ctrl_q[`PPE_CT_ACK_IRQ_ENABLE]) || (irq_q && !stat_rd); // see R11 see R25
      if (wr_lead) begin
         if (IO_ADDR == `PPE_OFF_DATA) begin // see R1
            data_d = HOST_DATA_BUS_IN;
         end else if (IO_ADDR == `PPE_OFF_CTRL) begin
            ctrl_d = HOST_DATA_BUS_IN;
            ctrl_d[`PPE_CT_DIR] = HOST_DATA_BUS_IN[`PPE_CT_DIR] && EPP_MODE; // see R10
         end else if (is_enh) begin
            pend_d = 1'b1;
            pend_ent_d = {IO_ADDR == `PPE_OFF_EADDR, 1'b0, HOST_DATA_BUS_IN}; // see R16 see R18
         end
      end
      if (rd_lead) begin
         if (IO_ADDR == `PPE_OFF_DATA) begin
            hout_d = data_q; // see R3
         end else if (IO_ADDR == `PPE_OFF_STATUS) begin
            hout_d = status_val;
         end else if (IO_ADDR == `PPE_OFF_CTRL) begin
            hout_d = ctrl_rb;
         end else if (is_enh) begin
            pend_d = 1'b1;
            rwait_d = 1'b1;
            pend_ent_d = {IO_ADDR == `PPE_OFF_EADDR, 1'b1, 8'h00}; // see R17 see R18
         end else begin
            hout_d = `PPE_UNMAPPED;
         end
      end
      if (done_q && cur_read_q) begin
         hout_d = erd_q; // see R17
         rwait_d = 1'b0;
      end
   end

   // host side registers
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         data_q <= `PPE_DATA_RST;
         ctrl_q <= `PPE_CTRL_RST;
         hout_q <= 8'h00;
         tmo_q <= 1'b0;
         irq_q <= 1'b0;
         ack_q <= 1'b1;
         rd_q <= 1'b1;
         wr_q <= 1'b1;
         pend_q <= 1'b0;
         pend_ent_q <= 10'h000;
         rwait_q <= 1'b0;
      end else begin
         data_q <= data_d;
         ctrl_q <= ctrl_d;
         hout_q <= hout_d;
         tmo_q <= tmo_d;
         irq_q <= irq_d;
         ack_q <= ack_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         pend_q <= pend_d;
         pend_ent_q <= pend_ent_d;
         rwait_q <= rwait_d;
      end
   end

   // two-entry request buffer
   assign buf_in_ready = (cnt_q != 2'h2);
   assign buf_out_valid = (cnt_q != 2'h0);
   assign buf_push = pend_q && buf_in_ready;
   assign buf_pop = buf_out_valid && (st_q == PPE_IDLE) && EPP_MODE;
   always_comb begin
      buf_d = buf_q;
      wptr_d = wptr_q ^ buf_push;
      rptr_d = rptr_q ^ buf_pop;
      cnt_d = cnt_q + 2'(buf_push) - 2'(buf_pop);
      if (buf_push) begin
         buf_d[wptr_q] = pend_ent_q;
      end
   end

   // buffer registers
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         buf_q[0] <= 10'h000;
         buf_q[1] <= 10'h000;
         wptr_q <= 1'b0;
         rptr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         buf_q <= buf_d;
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q <= cnt_d;
      end
   end

   // enhanced cycle engine with watchdog
   always_comb begin
      st_d = st_q;
      tcnt_d = tcnt_q;
      seen_d = seen_q;
      cur_addr_d = cur_addr_q;
      cur_read_d = cur_read_q;
      cur_data_d = cur_data_q;
      erd_d = erd_q;
      done_d = 1'b0;
      tmo_set = 1'b0;
      case (st_q)
         PPE_IDLE: begin
            tcnt_d = 7'h00;
            seen_d = 1'b0;
            if (buf_pop) begin
               {cur_addr_d, cur_read_d, cur_data_d} = buf_q[rptr_q];
               st_d = (EPP_V19 && BUSY_WAIT_IN) ? PPE_WLOW : PPE_STRB; // see R24
            end
         end
         PPE_WLOW: begin
            tcnt_d = tcnt_q + 7'h01;
            if (!BUSY_WAIT_IN) begin
               st_d = PPE_STRB; // see R24
               seen_d = 1'b1;
            end
         end
         PPE_STRB: begin
            tcnt_d = tcnt_q + 7'h01;
            seen_d = seen_q || !BUSY_WAIT_IN;
            if (BUSY_WAIT_IN && seen_q) begin
               st_d = PPE_END; // see R20
               erd_d = PARALLEL_DATA_LINES_IN; // see R17 see R18
            end
         end
         PPE_END: begin
            st_d = PPE_IDLE;
            done_d = 1'b1;
         end
         default: begin
            st_d = PPE_IDLE;
         end
      endcase
      if ((st_q == PPE_WLOW || st_q == PPE_STRB) && tcnt_q == TMO_LAST) begin
         st_d = PPE_IDLE; // see R23
         tmo_set = 1'b1; // see R8
         done_d = 1'b1;
         erd_d = PARALLEL_DATA_LINES_IN;
      end
   end

   // engine registers
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         st_q <= PPE_IDLE;
         tcnt_q <= 7'h00;
         seen_q <= 1'b0;
         cur_addr_q <= 1'b0;
         cur_read_q <= 1'b0;
         cur_data_q <= 8'h00;
         erd_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tcnt_q <= tcnt_d;
         seen_q <= seen_d;
         cur_addr_q <= cur_addr_d;
         cur_read_q <= cur_read_d;
         cur_data_q <= cur_data_d;
         erd_q <= erd_d;
         done_q <= done_d;
      end
   end

   // host bus outputs
   assign HOST_DATA_BUS_OUT = hout_q;
   assign HOST_DATA_BUS_OE = !IO_RD_N;
   assign HOST_READY = !pend_q && !rwait_q;
   assign HOST_IRQ = irq_q; // see R25

   // pin drive: engine owns pins during a cycle, control and data latches otherwise
   always_comb begin
      if (st_q != PPE_IDLE) begin
         DATA_STROBE_OUT_N = cur_read_q; // see R19
         AUTO_LINEFEED_OUT_N = !(st_q == PPE_STRB && !cur_addr_q); // see R19
         SELECT_IN_OUT_N = !(st_q == PPE_STRB && cur_addr_q); // see R19
         PARALLEL_DATA_LINES_OUT = cur_data_q; // see R16 see R18
         PARALLEL_DATA_LINES_OE = !cur_read_q;
      end else begin
         DATA_STROBE_OUT_N = !ctrl_q[`PPE_CT_STB]; // see R15
         AUTO_LINEFEED_OUT_N = !ctrl_q[`PPE_CT_AFD]; // see R14
         SELECT_IN_OUT_N = !ctrl_q[`PPE_CT_SELECT_CTRL_BIT]; // see R12
         PARALLEL_DATA_LINES_OUT = data_q;
         PARALLEL_DATA_LINES_OE = !EPP_MODE || !ctrl_q[`PPE_CT_DIR]; // see R10
      end
   end
   assign PERIPHERAL_INIT_OUT_N = ctrl_q[`PPE_CT_INIT]; // see R13 see R21

   // checks
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);

   rsv_status_a: assert property (stat_rd |=> HOST_DATA_BUS_OUT[2:1] == 2'b11) // see R7
      else $error("reserved status bits not one");
   ctrl_high_a: assert property (rd_lead && IO_ADDR == `PPE_OFF_CTRL |=> HOST_DATA_BUS_OUT[7:6] == 2'b11) // see R9
      else $error("control bits 7:6 not one");
   busy_inv_a: assert property (stat_rd |=> HOST_DATA_BUS_OUT[7] == !$past(BUSY_WAIT_IN)) // see R4
      else $error("busy bit not inverted pin");
   data_rb_a: assert property (rd_lead && IO_ADDR == `PPE_OFF_DATA |=> HOST_DATA_BUS_OUT == $past(data_q)) // see R3
      else $error("data readback mismatch");
   enh_gate_a: assert property (!EPP_MODE && (rd_lead || wr_lead) && enh_port(IO_ADDR) && !pend_q
      |=> !pend_q) // see R2
      else $error("enhanced port answered outside mode");
   wdog_abort_a: assert property (st_q == PPE_STRB && tcnt_q == TMO_LAST && !stat_clr
      |=> st_q == PPE_IDLE && tmo_q) // see R23
      else $error("watchdog did not abort");
   tmo_clr_a: assert property (tmo_q && stat_clr && !tmo_set |=> !tmo_q) // see R8
      else $error("timeout flag not cleared");
   v19_hold_a: assert property (st_q == PPE_WLOW |-> AUTO_LINEFEED_OUT_N && SELECT_IN_OUT_N) // see R24
      else $error("strobe while wait high");
   strb_kind_a: assert property (st_q == PPE_STRB |-> (AUTO_LINEFEED_OUT_N == cur_addr_q)
      && (SELECT_IN_OUT_N == !cur_addr_q) && (DATA_STROBE_OUT_N == cur_read_q)) // see R19
      else $error("wrong strobe for cycle kind");
   wr_drive_a: assert property (st_q == PPE_STRB && !cur_read_q
      |-> PARALLEL_DATA_LINES_OE && PARALLEL_DATA_LINES_OUT == cur_data_q) // see R16
      else $error("write data not driven");
   ack_irq_a: assert property (ack_rise && ctrl_q[`PPE_CT_ACK_IRQ_ENABLE] |=> HOST_IRQ [*2]) // see R11
      else $error("acknowledge interrupt lost");

   wr_cyc_c: cover property (st_q == PPE_END && !cur_read_q);
   rd_cyc_c: cover property (done_q && cur_read_q && !tmo_q);
   tmo_c: cover property (tmo_set);
   full_c: cover property (cnt_q == 2'h2);

endmodule : ppe_port
`default_nettype wire

// *** tb/ppe_periph_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ppe_periph_model (
   // clock and knobs
   input wire logic clk,
   input wire logic srst,
   input wire logic en,
   input wire logic stall,
   input wire logic busy_spp,
   input wire logic [7:0] dly,
   input wire logic [7:0] rd_val,
   // device pins
   input wire logic dstb_n,
   input wire logic astb_n,
   input wire logic dir_n,
   input wire logic [7:0] dev_out,
   input wire logic dev_oe,
   // back to device and bench
   output logic wait_o,
   output logic [7:0] lines,
   output logic [7:0] last_d,
   output logic [7:0] last_a,
   output logic [7:0] n_cyc
);
   logic act;
   logic wait_q;
   logic [7:0] cnt;
   logic [7:0] drv;
   assign act = en && !(dstb_n && astb_n);
   // wait low while ready, high dly+1 cycles after the strobe, held until the strobe drops
   always @(posedge clk) begin
      if (srst || !act) begin
         cnt <= 8'h00;
         wait_q <= 1'b0;
      end else begin
         if (cnt != 8'hFF) cnt <= cnt + 8'h01;
         if (cnt == dly && !stall && !wait_q) begin
            wait_q <= 1'b1;
            n_cyc <= n_cyc + 8'h01;
            if (!dir_n && !dstb_n) last_d <= lines;
            if (!dir_n && !astb_n) last_a <= lines;
         end
      end
      if (srst) n_cyc <= 8'h00;
      // read byte while asked, else a pattern that changes every cycle
      drv <= srst ? 8'h00 : (act && dir_n) ? rd_val : ~drv;
   end
   // in enhanced mode busy_spp forces wait high, so the peripheral is not yet ready
   assign wait_o = en ? (wait_q || busy_spp) : busy_spp;
   assign lines = dev_oe ? dev_out : drv;
endmodule : ppe_periph_model
`default_nettype wire

// *** tb/parallel_printer_epp_port_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module parallel_printer_epp_port_bench;
   import ppe_pkg::*;
   logic REF_CLK = 1'b0, SRST = 1'b1, IO_RD_N = 1'b1, IO_WR_N = 1'b1, EPP_MODE = 1'b0, EPP_V19 = 1'b0;
   logic [2:0] IO_ADDR = 3'h0;
   logic [7:0] HOST_DATA_BUS_IN = 8'h00, HOST_DATA_BUS_OUT, PARALLEL_DATA_LINES_IN, PARALLEL_DATA_LINES_OUT;
   logic HOST_DATA_BUS_OE, HOST_READY, HOST_IRQ, PARALLEL_DATA_LINES_OE, DATA_STROBE_OUT_N;
   logic AUTO_LINEFEED_OUT_N, PERIPHERAL_INIT_OUT_N, SELECT_IN_OUT_N, BUSY_WAIT_IN;
   logic ACKNOWLEDGE_IN_N = 1'b1, PAPER_END_IN = 1'b0, SELECTED_IN = 1'b0, FAULT_IN_N = 1'b1;
   logic busy = 1'b0, stall = 1'b0;
   logic [7:0] rd_val = 8'h00, dly = 8'h02, got, last_d, last_a, n_cyc;
   int miscompares = 0, checks = 0;
   ppe_port u_dut (.*);
   ppe_periph_model u_per (.clk(REF_CLK), .srst(SRST), .en(EPP_MODE), .stall(stall), .busy_spp(busy),
      .dly(dly), .rd_val(rd_val), .dstb_n(AUTO_LINEFEED_OUT_N), .astb_n(SELECT_IN_OUT_N),
      .dir_n(DATA_STROBE_OUT_N), .dev_out(PARALLEL_DATA_LINES_OUT), .dev_oe(PARALLEL_DATA_LINES_OE),
      .wait_o(BUSY_WAIT_IN), .lines(PARALLEL_DATA_LINES_IN), .last_d(last_d), .last_a(last_a), .n_cyc(n_cyc));
   // 10 mhz clock
   always #50 REF_CLK = ~REF_CLK;
   task automatic step(input int n);
      repeat (n) @(posedge REF_CLK);
      #10;
   endtask : step
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // one host access: strobe held until ready is seen high at an edge
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      int n;
      IO_ADDR = a;
      HOST_DATA_BUS_IN = d;
      if (w) IO_WR_N = 1'b0;
      else IO_RD_N = 1'b0;
      step(2);
      for (n = 0; n < 400 && HOST_READY !== 1'b1; n++) step(1);
      if (n == 400) begin
         miscompares++;
         tally_and_finish();
      end
      step(1);
      got = HOST_DATA_BUS_OUT;
      IO_WR_N = 1'b1;
      IO_RD_N = 1'b1;
      step(1);
   endtask : acc
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK(got, e)
   endtask : rd
   task automatic ack_pulse();
      ACKNOWLEDGE_IN_N = 1'b0;
      step(3);
      ACKNOWLEDGE_IN_N = 1'b1;
      step(4);
   endtask : ack_pulse
   // main sequence
   initial begin
      step(5);
      SRST = 1'b0;
      step(1);
      `CHK({PERIPHERAL_INIT_OUT_N, DATA_STROBE_OUT_N, PARALLEL_DATA_LINES_OE, HOST_IRQ}, 4'hE)
      rd(3'h2, 8'hC4);
      wr(3'h0, 8'hA5);
      rd(3'h0, 8'hA5);
      `CHK(PARALLEL_DATA_LINES_OUT, 8'hA5)
      wr(3'h2, 8'h2B);
      `CHK({DATA_STROBE_OUT_N, AUTO_LINEFEED_OUT_N, PERIPHERAL_INIT_OUT_N, SELECT_IN_OUT_N}, 4'h0)
      rd(3'h2, 8'hCB);
      step(500);
      wr(3'h2, 8'hC4);
      $display("test control done");
      for (int i = 0; i < 32; i++) begin
         {busy, ACKNOWLEDGE_IN_N, PAPER_END_IN, SELECTED_IN, FAULT_IN_N} = i[4:0];
         step(3);
         rd(3'h1, {~i[4], i[3:0], 3'h6});
      end
      busy = 1'b0;
      PAPER_END_IN = 1'b0;
      wr(3'h3, 8'h3C);
      `CHK(PARALLEL_DATA_LINES_OUT, 8'hA5)
      for (int a = 3; a < 8; a++) rd(a[2:0], 8'hFF);
      $display("test status done");
      wr(3'h2, 8'hD4);
      ack_pulse();
      `CHK(HOST_IRQ, 1'b1)
      rd(3'h1, 8'hDE);
      `CHK(HOST_IRQ, 1'b0)
      wr(3'h2, 8'hC4);
      ack_pulse();
      `CHK(HOST_IRQ, 1'b0)
      $display("test interrupt done");
      EPP_MODE = 1'b1;
      wr(3'h3, 8'h3C);
      for (int a = 4; a < 8; a++) begin
         wr(a[2:0], 8'h10 + a[7:0]);
         step(10);
         `CHK(last_d, 8'h10 + a[7:0])
      end
      `CHK(last_a, 8'h3C)
      `CHK(n_cyc, 8'h05)
      dly = 8'h1E;
      wr(3'h4, 8'h11);
      wr(3'h5, 8'h22);
      wr(3'h6, 8'h33);
      rd_val = 8'h96;
      rd(3'h4, 8'h96);
      `CHK({n_cyc, last_d}, 16'h0933)
      rd_val = 8'h69;
      rd(3'h3, 8'h69);
      dly = 8'h02;
      EPP_V19 = 1'b1;
      busy = 1'b1;
      wr(3'h7, 8'h5C);
      step(10);
      `CHK({AUTO_LINEFEED_OUT_N, last_d}, 9'h133)
      busy = 1'b0;
      step(10);
      `CHK(last_d, 8'h5C)
      wr(3'h2, 8'hD4);
      ack_pulse();
      `CHK(HOST_IRQ, 1'b1)
      rd(3'h1, 8'hDE);
      `CHK(HOST_IRQ, 1'b0)
      wr(3'h2, 8'hE4);
      rd(3'h2, 8'hE4);
      `CHK(PARALLEL_DATA_LINES_OE, 1'b0)
      wr(3'h2, 8'hC4);
      $display("test enhanced cycles done");
      stall = 1'b1;
      wr(3'h4, 8'hEE);
      step(110);
      rd(3'h1, 8'hDF);
      `CHK(last_d, 8'h5C)
      stall = 1'b0;
      wr(3'h1, 8'h00);
      rd(3'h1, 8'hDF);
      wr(3'h1, 8'h01);
      rd(3'h1, 8'hDE);
      $display("test timeout done");
      tally_and_finish();
   end
endmodule : parallel_printer_epp_port_bench
`default_nettype wire
